//--- src/frp_pkg.sv
package frp_pkg;

  // Power and reset states, Gray coded along off, cold, run, warm, held
  typedef enum logic [2:0] {
    FRP_ST_OFF  = 3'h0,
    FRP_ST_COLD = 3'h1,
    FRP_ST_RUN  = 3'h3,
    FRP_ST_WARM = 3'h2,
    FRP_ST_HELD = 3'h6
  } frp_state_t;

endpackage

//--- src/frp_regs.svh
`ifndef FRP_REGS_SVH
`define FRP_REGS_SVH

// ****************************************
// Clock and timing figures
// ****************************************
`define FRP_CLK_KHZ            40000
`define FRP_PU_INTERVAL_NS     300000
`define FRP_RESTART_HOLD_NS    35000
`define FRP_MIN_LOW_PULSE_NS   200
`define FRP_REARM_SETUP_NS     50
`define FRP_DESELECT_HOLD_NS   50

// Longest time: rounded down; clock taken in whole MHz so products stay in 32 bits
`define FRP_PU_CYC             ((`FRP_PU_INTERVAL_NS * (`FRP_CLK_KHZ / 1000)) / 1000)
// Least times: rounded up
`define FRP_RESTART_HOLD_CYC   ((`FRP_RESTART_HOLD_NS * (`FRP_CLK_KHZ / 1000) + 999) / 1000)
`define FRP_MIN_LOW_PULSE_CYC  ((`FRP_MIN_LOW_PULSE_NS * (`FRP_CLK_KHZ / 1000) + 999) / 1000)

// Counter width and link byte size
`define FRP_CNT_W              16
`define FRP_CMD_BITS           8

`endif

//--- src/frp_reset_power.sv
`timescale 1ns/1ps
`include "frp_regs.svh"

// Operation
// - Chip select low means active power state
// - Stay active until pending work finishes
// - Cold init runs for power-up interval
// - Reset pin ignored during cold init
// - Reset fall restores cold-init register values
// - Warm reset shortcut, done within pulse hold
// - Failed cold init: reset reruns cold sequence
// - Valid low pulse aborts work, outputs float
// - Reject commands during restart pulse hold
// - Hardware reset ends with interface in standby
// - Restart pulse hold at least 35 us
module frp_reset_power
  import frp_pkg::*;
#(
  parameter int PU_CYC = `FRP_PU_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       link_clk_i,
  input  wire logic       cs_n_i,
  input  wire logic       si_i,
  input  wire logic       reset_n_i,
  input  wire logic       vcc_ok_i,
  input  wire logic       busy_i,
  input  wire logic       init_fail_i,
  output logic            active_o,
  output logic            standby_o,
  output logic            cold_busy_o,
  output logic            warm_busy_o,
  output logic            regs_reset_o,
  output logic            abort_o,
  output logic            out_hiz_o,
  output logic [7:0]      cmd_byte_o,
  output logic            cmd_accept_o,
  output logic            cmd_reject_o
);

  localparam logic [`FRP_CNT_W-1:0] PU_LAST   = `FRP_CNT_W'(PU_CYC - 1);
  localparam logic [`FRP_CNT_W-1:0] HOLD_LAST = `FRP_CNT_W'(`FRP_RESTART_HOLD_CYC - 1);
  localparam logic [`FRP_CNT_W-1:0] LOW_LAST  = `FRP_CNT_W'(`FRP_MIN_LOW_PULSE_CYC - 1);

  // Counter reached its last value
  function automatic logic cnt_at(input logic [`FRP_CNT_W-1:0] cnt, input logic [`FRP_CNT_W-1:0] last);
    cnt_at = (cnt >= last);
  endfunction

  // ****************************************
  // Link side: command byte capture on the serial clock
  // ****************************************
  logic [7:0] link_shift_q;
  logic [2:0] link_bits_q;
  logic       link_tgl_q;
  logic [7:0] link_byte_q;

  // Bit counter cleared by deselect, so a stopped clock leaves nothing hanging
  always_ff @(posedge link_clk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      link_bits_q  <= 3'h0;
      link_shift_q <= 8'h00;
    end else begin
      link_bits_q  <= link_bits_q + 3'h1;
      link_shift_q <= {link_shift_q[6:0], si_i};
    end
  end

  // Whole byte: hold it and flip the event toggle; reset keeps toggle in step with the sys side
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_byte_q <= 8'h00;
      link_tgl_q  <= 1'b0;
    end else if (!cs_n_i && link_bits_q == 3'(`FRP_CMD_BITS - 1)) begin
      link_byte_q <= {link_shift_q[6:0], si_i};
      link_tgl_q  <= ~link_tgl_q;
    end
  end

  // ****************************************
  // Pin and crossing synchronisers
  // ****************************************
  logic [1:0] cs_sync_q;
  logic [1:0] rst_pin_sync_q;
  logic [1:0] vcc_sync_q;
  logic [1:0] tgl_sync_q;
  logic       tgl_seen_q;
  logic       cs_n_s;
  logic       pin_low_s;
  logic       vcc_ok_s;
  logic       byte_evt;

  // Two flops per asynchronous input
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cs_sync_q      <= 2'h3;
      rst_pin_sync_q <= 2'h3;
      vcc_sync_q     <= 2'h0;
      tgl_sync_q     <= 2'h0;
      tgl_seen_q     <= 1'b0;
    end else if (ce_i) begin
      cs_sync_q      <= {cs_sync_q[0], cs_n_i};
      rst_pin_sync_q <= {rst_pin_sync_q[0], reset_n_i};
      vcc_sync_q     <= {vcc_sync_q[0], vcc_ok_i};
      tgl_sync_q     <= {tgl_sync_q[0], link_tgl_q};
      tgl_seen_q     <= tgl_sync_q[1];
    end
  end

  assign cs_n_s    = cs_sync_q[1];
  assign pin_low_s = ~rst_pin_sync_q[1];
  assign vcc_ok_s  = vcc_sync_q[1];
  assign byte_evt  = tgl_sync_q[1] ^ tgl_seen_q;

  // ****************************************
  // Reset pin pulse measurement
  // ****************************************
  logic [`FRP_CNT_W-1:0] low_cnt_q;
  logic                  armed_q;
  logic                  trig;

  // Low time counter, saturating at the minimum pulse width
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      low_cnt_q <= '0;
    end else if (ce_i) begin
      if (!pin_low_s) begin
        low_cnt_q <= '0;
      end else if (!cnt_at(low_cnt_q, LOW_LAST)) begin
        low_cnt_q <= low_cnt_q + `FRP_CNT_W'(1);
      end
    end
  end

  // A pulse only counts once it has lasted the minimum width
  assign trig = armed_q && pin_low_s && cnt_at(low_cnt_q, LOW_LAST);

  // ****************************************
  // Power and reset sequencer
  // ****************************************
  frp_state_t            state_q;
  logic [`FRP_CNT_W-1:0] cnt_q;
  logic                  cold_ok_q;

  // Main state and interval counter
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= FRP_ST_OFF;
      cnt_q   <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_q + `FRP_CNT_W'(1);
      if (!vcc_ok_s) begin
        state_q <= FRP_ST_OFF;
        cnt_q   <= '0;
      end else begin
        case (state_q)
          FRP_ST_OFF: begin
            state_q <= FRP_ST_COLD;
            cnt_q   <= '0;
          end
          FRP_ST_COLD: begin
            // Reset pin not looked at until the interval ends
            if (cnt_at(cnt_q, PU_LAST)) begin
              state_q <= pin_low_s ? FRP_ST_HELD : FRP_ST_RUN;
            end
          end
          FRP_ST_RUN: begin
            cnt_q <= '0;
            if (trig) begin
              state_q <= cold_ok_q ? FRP_ST_WARM : FRP_ST_COLD;
            end
          end
          FRP_ST_WARM: begin
            if (cnt_at(cnt_q, HOLD_LAST)) begin
              state_q <= FRP_ST_RUN;
            end
          end
          FRP_ST_HELD: begin
            if (!pin_low_s) begin
              state_q <= FRP_ST_RUN;
            end
          end
          default: begin
            state_q <= FRP_ST_OFF;
          end
        endcase
      end
    end
  end

  // Cold init outcome, caught at the end of the interval
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cold_ok_q <= 1'b0;
    end else if (ce_i) begin
      if (state_q == FRP_ST_COLD && cnt_at(cnt_q, PU_LAST)) begin
        cold_ok_q <= ~init_fail_i;
      end else if (!vcc_ok_s) begin
        cold_ok_q <= 1'b0;
      end
    end
  end

  // Re-arm: pin must be seen high again after a reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (ce_i) begin
      if (trig && state_q == FRP_ST_RUN) begin
        armed_q <= 1'b0;
      end else if (!pin_low_s) begin
        armed_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  logic run;
  assign run = (state_q == FRP_ST_RUN);

  // Power state, reset pulses and status
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      active_o     <= 1'b0;
      standby_o    <= 1'b0;
      cold_busy_o  <= 1'b0;
      warm_busy_o  <= 1'b0;
      regs_reset_o <= 1'b0;
      abort_o      <= 1'b0;
      out_hiz_o    <= 1'b1;
    end else if (ce_i) begin
      active_o     <= run && (!cs_n_s || busy_i);
      standby_o    <= run && cs_n_s && !busy_i;
      cold_busy_o  <= (state_q == FRP_ST_COLD);
      warm_busy_o  <= (state_q == FRP_ST_WARM);
      regs_reset_o <= run && trig;
      abort_o      <= run && trig;
      out_hiz_o    <= !run || trig;
    end
  end

  // Command bytes: accepted only when running
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cmd_byte_o   <= 8'h00;
      cmd_accept_o <= 1'b0;
      cmd_reject_o <= 1'b0;
    end else if (ce_i) begin
      cmd_accept_o <= byte_evt && run;
      cmd_reject_o <= byte_evt && !run;
      if (byte_evt) begin
        cmd_byte_o <= link_byte_q;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_warm_entry;
    ce_i && run && trig && cold_ok_q && vcc_ok_s;
  endsequence

  sequence s_warm_done;
    ce_i && state_q == FRP_ST_WARM && cnt_at(cnt_q, HOLD_LAST) && vcc_ok_s;
  endsequence

  a_select_active: assert property (ce_i && run && !cs_n_s |=> active_o)
    else $error("select low but not active");
  a_busy_active: assert property (ce_i && run && busy_i |=> active_o && !standby_o)
    else $error("pending work but not active");
  a_cold_length: assert property (state_q == FRP_ST_COLD |-> cnt_q <= PU_LAST)
    else $error("cold interval overran");
  a_cold_ignore: assert property (ce_i && state_q == FRP_ST_COLD && !cnt_at(cnt_q, PU_LAST) && vcc_ok_s
                                  |=> state_q == FRP_ST_COLD)
    else $error("cold init left early");
  a_held_wait: assert property (ce_i && state_q == FRP_ST_HELD && pin_low_s && vcc_ok_s
                                |=> state_q == FRP_ST_HELD)
    else $error("left held state with pin low");
  a_regs_reset: assert property (s_warm_entry |=> regs_reset_o && abort_o && state_q == FRP_ST_WARM)
    else $error("warm reset without register reset");
  a_warm_short: assert property (state_q == FRP_ST_WARM |-> cnt_q <= HOLD_LAST)
    else $error("warm reset overran hold");
  a_warm_first: assert property (s_warm_entry ##1 ce_i |=> state_q == FRP_ST_WARM && cnt_q == `FRP_CNT_W'(1))
    else $error("warm count did not start");
  a_bad_cold: assert property (ce_i && run && trig && !cold_ok_q && vcc_ok_s |=> state_q == FRP_ST_COLD)
    else $error("failed init did not rerun cold");
  a_float: assert property (ce_i && !run |=> out_hiz_o)
    else $error("outputs driven outside run");
  a_reject: assert property (cmd_accept_o |-> $past(run))
    else $error("command accepted during reset");
  a_standby_end: assert property (s_warm_done ##1 (ce_i && cs_n_s && !busy_i) |=> standby_o)
    else $error("not in standby after reset");
  a_short_pulse: assert property (ce_i && run && pin_low_s && !cnt_at(low_cnt_q, LOW_LAST) |=> !regs_reset_o)
    else $error("short pulse caused reset");

endmodule // frp_reset_power

//--- verification/frp_host_model.sv
`timescale 1ns/1ps

// ****************************************
// Host flash controller seen from the pins
// ****************************************
module frp_host_model (
  output logic link_clk_o,
  output logic cs_n_o,
  output logic si_o,
  output logic reset_n_o
);
  // Idle: deselected, reset released, serial clock parked low
  initial begin
    link_clk_o = 1'b0;
    cs_n_o     = 1'b1;
    si_o       = 1'b0;
    reset_n_o  = 1'b1;
  end

  // Select level without any clocking
  task automatic set_cs(input logic v);
    cs_n_o = v;
  endtask

  // Reset pin level without any timing
  task automatic set_reset(input logic v);
    reset_n_o = v;
  endtask

  // One byte, MSB first, clock runs only inside the frame
  task automatic send_byte(input logic [7:0] b);
    cs_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      si_o = b[i];
      #62.5 link_clk_o = 1'b1;
      #62.5 link_clk_o = 1'b0;
    end
    #62.5 cs_n_o = 1'b1;
    si_o = ~b[0]; // Released line shows no stale bit
  endtask

  // Low pulse, then high long enough for setup and deselect hold
  task automatic pulse_reset(input int low_ns);
    cs_n_o    = 1'b1;
    reset_n_o = 1'b0;
    #(low_ns) reset_n_o = 1'b1;
    #100;
  endtask
endmodule // frp_host_model

//--- verification/tb.sv
`timescale 1ns/1ps

module tb;
  import frp_pkg::*;
  localparam int PU   = 40;
  localparam int HOLD = 1400;
  logic       sys_clk_i, rst_i, ce_i, vcc_ok_i, busy_i, init_fail_i, hit;
  logic       link_clk, cs_n, si, reset_n;
  logic       active_o, standby_o, cold_busy_o, warm_busy_o, regs_reset_o;
  logic       abort_o, out_hiz_o, cmd_accept_o, cmd_reject_o;
  logic [7:0] cmd_byte_o;
  logic [3:0] rows [5] = '{4'b1001, 4'b0010, 4'b1110, 4'b0110, 4'b1001};
  int         bad_count = 0, compares = 0, cycles = 0, pulses = 0, n;

  // ****************************************
  // Design and host
  // ****************************************
  frp_reset_power #(.PU_CYC(PU)) u_frp_reset_power (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .link_clk_i(link_clk),
    .cs_n_i(cs_n), .si_i(si), .reset_n_i(reset_n), .vcc_ok_i(vcc_ok_i),
    .busy_i(busy_i), .init_fail_i(init_fail_i), .active_o(active_o),
    .standby_o(standby_o), .cold_busy_o(cold_busy_o), .warm_busy_o(warm_busy_o),
    .regs_reset_o(regs_reset_o), .abort_o(abort_o), .out_hiz_o(out_hiz_o),
    .cmd_byte_o(cmd_byte_o), .cmd_accept_o(cmd_accept_o), .cmd_reject_o(cmd_reject_o));

  frp_host_model u_frp_host_model (
    .link_clk_o(link_clk), .cs_n_o(cs_n), .si_o(si), .reset_n_o(reset_n));

  // System clock
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Restore pulse counter and run ceiling
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (regs_reset_o === 1'b1) pulses <= pulses + 1;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    tick(3);
    rst_i = 1'b0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return cold_busy_o;
      1: return regs_reset_o;
      2: return cmd_accept_o;
      3: return cmd_reject_o;
      default: return warm_busy_o;
    endcase
  endfunction

  task automatic wait_for(input int s, input int lim, output logic h);
    h = 1'b0;
    for (int i = 0; i < lim && !h; i++) begin
      tick(1);
      h = (sig(s) === 1'b1);
    end
  endtask

  task automatic count_high(input int s, output int k);
    k = 0;
    while (sig(s) === 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    vcc_ok_i = 1'b0;
    busy_i = 1'b0;
    init_fail_i = 1'b0;
    do_reset();
    vcc_ok_i = 1'b1;
    wait_for(0, 10, hit);
    chk("cold_start", 16'h1, 16'(hit));
    fork
      count_high(0, n);
      u_frp_host_model.pulse_reset(300);
    join
    chk("cold_len", 16'(PU), 16'(n));
    chk("pin_ignored_cold", 16'h0, 16'(pulses));
    // Power state table: select, busy, active, standby
    foreach (rows[i]) begin
      u_frp_host_model.set_cs(rows[i][3]);
      busy_i = rows[i][2];
      tick(5);
      chk("active", 16'(rows[i][1]), 16'(active_o));
      chk("standby", 16'(rows[i][0]), 16'(standby_o));
    end
    // Clock enable low freezes the power state
    ce_i = 1'b0;
    u_frp_host_model.set_cs(1'b0);
    tick(5);
    chk("frozen", 16'h0, 16'(active_o));
    ce_i = 1'b1;
    tick(5);
    chk("thawed", 16'h1, 16'(active_o));
    u_frp_host_model.set_cs(1'b1);
    tick(5);
    fork
      u_frp_host_model.send_byte(8'hA5);
      wait_for(2, 60, hit);
    join
    tick(1);
    chk("accept", 16'h1, 16'(hit));
    chk("cmd_byte", 16'h00A5, 16'(cmd_byte_o));
    // Warm reset with a command pushed into the hold on purpose
    fork
      u_frp_host_model.pulse_reset(300);
      begin
        wait_for(1, 20, hit);
        chk("restore", 16'h1, 16'(hit));
        chk("abort", 16'h1, 16'(abort_o));
        chk("hiz", 16'h1, 16'(out_hiz_o));
      end
    join
    fork
      count_high(4, n);
      u_frp_host_model.send_byte(8'h3C);
      begin
        wait_for(3, 60, hit);
        chk("reject_in_hold", 16'h1, 16'(hit));
      end
    join
    chk("warm_len", 16'h1, 16'(n > HOLD - 30 && n <= HOLD));
    tick(3);
    chk("standby_after", 16'h1, 16'(standby_o));
    chk("hiz_after", 16'h0, 16'(out_hiz_o));
    n = pulses;
    u_frp_host_model.pulse_reset(100);
    tick(20);
    chk("short_pulse", 16'(n), 16'(pulses));
    // Failed cold start, then the pin reruns the cold sequence
    do_reset();
    init_fail_i = 1'b1;
    wait_for(0, 10, hit);
    count_high(0, n);
    init_fail_i = 1'b0;
    tick(5);
    fork
      u_frp_host_model.pulse_reset(300);
      begin
        wait_for(0, 20, hit);
        count_high(0, n);
      end
    join
    chk("cold_rerun", 16'h1, 16'(hit));
    chk("cold_rerun_len", 16'(PU), 16'(n));
    chk("no_warm", 16'h0, 16'(warm_busy_o));
    // Pin held low through the end of power-up, then released
    vcc_ok_i = 1'b0;
    tick(5);
    u_frp_host_model.set_reset(1'b0);
    vcc_ok_i = 1'b1;
    wait_for(0, 10, hit);
    count_high(0, n);
    tick(3);
    chk("held_standby", 16'h0, 16'(standby_o));
    chk("held_hiz", 16'h1, 16'(out_hiz_o));
    u_frp_host_model.set_reset(1'b1);
    tick(5);
    chk("held_exit", 16'h1, 16'(standby_o));
    final_report();
  end
endmodule // tb
